// [shared/sppe_pkg.sv]
package sppe_pkg;
    // Register bus geometry
    localparam int ADR_W = 12;
    localparam int DAT_W = 32;
    // Register byte offsets
    localparam logic [ADR_W-1:0] ADR_TIME_MEASURE = 12'h268;
    localparam logic [ADR_W-1:0] ADR_CLKREQ_WAIT = 12'h300;
    localparam logic [ADR_W-1:0] ADR_L1SS_DELAY = 12'h304;
    localparam logic [ADR_W-1:0] ADR_SPARE_TWO = 12'h308;
    localparam logic [ADR_W-1:0] ADR_SPARE_THREE = 12'h30C;
    localparam logic [ADR_W-1:0] ADR_SPARE_FOUR = 12'h310;
    localparam logic [ADR_W-1:0] ADR_ERR_COUNTER = 12'h318;
    // Field positions
    localparam int PTM_EN_BIT = 0;
    localparam int PTM_ROOT_BIT = 1;
    localparam int GRAN_LSB = 8;
    localparam int GRAN_W = 8;
    localparam int WAIT_W = 20;
    localparam int DELAY_W = 16;
    localparam int HW_DELAY_LSB = 16;
    localparam int CNT_W = 16;
    localparam int FLAG_LSB = 16;
    localparam int FLAG_N = 3;
    localparam int SEL_LSB = 24;
    localparam int SEL_W = 5;
    localparam int CNT_CLR_BIT = 30;
    localparam int CNT_EN_BIT = 31;
    // Reset values
    localparam logic [WAIT_W-1:0] WAIT_RST = 20'h0_0FFF;
    localparam logic [DELAY_W-1:0] DELAY_RST = 16'h01FF;
    localparam logic [DAT_W-1:0] SPARE_RST = 32'h0000_0000;
    localparam logic [DAT_W-1:0] SPARE_FOUR_RST = 32'h000F_FFFF;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    // Timing units in ns
    localparam int CLK_PERIOD_NS = 8;
    localparam int WAIT_UNIT_NS = 10;
    localparam int DELAY_UNIT_NS = 4;
    localparam int NS_W = 26;
    // Counted event selector codes
    localparam logic [SEL_W-1:0] EVT_TRAINING = 5'h00;
    localparam logic [SEL_W-1:0] EVT_UNCORR = 5'h01;
    localparam logic [SEL_W-1:0] EVT_ACCESS = 5'h03;
    localparam logic [SEL_W-1:0] EVT_REPLAY = 5'h06;
    localparam logic [SEL_W-1:0] EVT_CPL_CREDIT = 5'h07;
    localparam logic [SEL_W-1:0] EVT_NP_CREDIT = 5'h08;
    localparam logic [SEL_W-1:0] EVT_POST_CREDIT = 5'h09;
    localparam logic [SEL_W-1:0] EVT_NACK_A = 5'h0A;
    localparam logic [SEL_W-1:0] EVT_NACK_B = 5'h0B;
    localparam logic [SEL_W-1:0] EVT_TX_RECOV = 5'h0D;
    localparam logic [SEL_W-1:0] EVT_RX_RECOV = 5'h0E;
    // Low-power substate controller states
    typedef enum logic [2:0] {
        L1SS_L0,
        L1SS_L1_DELAY,
        L1SS_RELEASE_WAIT,
        L1SS_L11,
        L1SS_L1_HOLD
    } sppe_l1ss_state_e;
endpackage

// [rtl/sppe_l1ss_ctrl.sv]
`timescale 1ns/1ps
module sppe_l1ss_ctrl (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Sync reset, active high
    input wire logic in_l1_i, // Port sits in L1
    input wire logic hw_ctrl_i, // L1 entered under hardware control
    input wire logic [sppe_pkg::DELAY_W-1:0] sw_delay_i, // Software entry delay
    input wire logic [sppe_pkg::DELAY_W-1:0] hw_delay_i, // Hardware entry delay
    input wire logic [sppe_pkg::WAIT_W-1:0] wait_i, // Partner release wait
    input wire logic clkreq_n_i, // Synchronised line level
    output logic drive_o, // Port pulls the line low
    output logic substate_o, // Port is in L1.1
    output logic fallback_o // One-cycle pulse on timeout
);
    import sppe_pkg::*;

    sppe_l1ss_state_e state_reg, state_next;
    logic [NS_W-1:0] elapsed_reg; // Time spent in current state, ns
    logic [NS_W-1:0] elapsed_next;
    logic [NS_W-1:0] elapsed_inc;
    logic [NS_W-1:0] delay_ns;
    logic [NS_W-1:0] wait_ns;
    logic [DELAY_W-1:0] delay_sel;
    wire delay_done;
    wire wait_done;
    wire fallback_next;

    // Entry delay steps 4 ns, wait steps 10 ns
    assign delay_sel = hw_ctrl_i ? hw_delay_i : sw_delay_i;
    assign delay_ns = NS_W'(delay_sel) * NS_W'(DELAY_UNIT_NS);
    assign wait_ns = NS_W'(wait_i) * NS_W'(WAIT_UNIT_NS);
    assign elapsed_inc = elapsed_reg + NS_W'(CLK_PERIOD_NS);
    assign delay_done = elapsed_inc >= delay_ns;
    assign wait_done = elapsed_inc >= wait_ns;
    assign fallback_next = (state_reg == L1SS_RELEASE_WAIT) && (state_next == L1SS_L1_HOLD);

    // Next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            L1SS_L0: begin
                if (in_l1_i) begin
                    state_next = L1SS_L1_DELAY;
                end
            end
            L1SS_L1_DELAY: begin
                if (!in_l1_i) begin
                    state_next = L1SS_L0;
                end else if (delay_done) begin
                    state_next = L1SS_RELEASE_WAIT;
                end
            end
            L1SS_RELEASE_WAIT: begin
                if (!in_l1_i) begin
                    state_next = L1SS_L0;
                end else if (clkreq_n_i) begin
                    state_next = L1SS_L11;
                end else if (wait_done) begin
                    state_next = L1SS_L1_HOLD;
                end
            end
            L1SS_L11: begin
                if (!in_l1_i) begin
                    state_next = L1SS_L0;
                end else if (!clkreq_n_i) begin
                    state_next = L1SS_L1_HOLD;
                end
            end
            L1SS_L1_HOLD: begin
                if (!in_l1_i) begin
                    state_next = L1SS_L0;
                end
            end
        endcase
    end

    // Timer restarts on every state change
    assign elapsed_next = (state_next != state_reg) ? '0 : elapsed_inc;

    // State, timer and registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= L1SS_L0;
            elapsed_reg <= '0;
            drive_o <= 1'b1;
            substate_o <= 1'b0;
            fallback_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            elapsed_reg <= elapsed_next;
            drive_o <= (state_next != L1SS_RELEASE_WAIT) && (state_next != L1SS_L11);
            substate_o <= (state_next == L1SS_RELEASE_WAIT) || (state_next == L1SS_L11);
            fallback_o <= fallback_next;
        end
    end

    chk_release_on_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == L1SS_L1_DELAY && state_next == L1SS_RELEASE_WAIT) |=> !drive_o)
        else $error("line still driven after L1.1 entry");
    chk_fallback_redrive: assert property (@(posedge clk_i) disable iff (rst_i)
        fallback_o |-> drive_o && !substate_o)
        else $error("fallback without driving the line");
endmodule

// [rtl/sppe_regs.sv]
// Operation
// - PTM participation only while enable set
// - Time root needs root select and enable
// - Granularity byte read/write, no effect
// - Release clock request on L1.1 entry
// - Partner late: redrive line, back to L1
// - Wait interval counts 10 ns, reset 0FFFh
// - Software L1.1 delay, 4 ns steps, 01FFh
// - Hardware L1.1 delay, 4 ns steps, 01FFh
// - Error counter counts only while enabled
// - Clear bit zeroes count, reads one
// - Selector codes for training to replay
// - Selector codes for credit, nack, recovery
// - Sticky credit flags, write one clears
`timescale 1ns/1ps
module sppe_regs (
    input wire logic clk_i, // Core clock, 125 MHz
    input wire logic rst_i, // Sync reset, active high
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Write enable
    input wire logic [sppe_pkg::ADR_W-1:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [sppe_pkg::DAT_W-1:0] wb_dat_i, // Write data
    output logic [sppe_pkg::DAT_W-1:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic training_err_i, // Training error pulse
    input wire logic uncorrectable_status_event_i, // Uncorrectable status pulse
    input wire logic acs_err_i, // Access-control error pulse
    input wire logic replay_rollover_i, // Replay rollover pulse
    input wire logic replay_timeout_i, // Replay timeout pulse
    input wire logic cpl_credit_err_i, // Completion credit error pulse
    input wire logic nonposted_credit_fault_i, // Non-posted credit error pulse
    input wire logic posted_credit_err_i, // Posted credit error pulse
    input wire logic rx_nack_i, // Received nack pulse
    input wire logic rx_recovery_i, // Receive recovery entry pulse
    input wire logic tx_recovery_i, // Transmit recovery entry pulse
    input wire logic in_l1_i, // Port is in L1
    input wire logic hw_ctrl_i, // L1 under hardware control
    input wire logic clock_request_n_i, // Clock request line level
    output logic clock_request_n_o, // Clock request drive value
    output logic clock_request_n_oe_n_o, // Low while pulling the line
    output logic l1_substate_o, // Port in L1.1
    output logic l1_fallback_o, // Pulse on partner timeout
    output logic ptm_active_o, // Time measurement permitted
    output logic ptm_root_o // Acting as time root
);
    import sppe_pkg::*;

    // Control and status storage
    logic ptm_en_reg; // Measurement enable
    logic ptm_root_reg; // Root selection
    logic [GRAN_W-1:0] gran_reg; // Effective granularity
    logic [WAIT_W-1:0] wait_reg; // Release wait interval
    logic [DELAY_W-1:0] sw_delay_reg; // Software entry delay
    logic [DELAY_W-1:0] hw_delay_reg; // Hardware entry delay
    logic [DAT_W-1:0] spare_two_reg; // Spare control word
    logic [DAT_W-1:0] spare_three_reg; // Spare control word
    logic [DAT_W-1:0] spare_four_reg; // Spare control word
    logic cnt_en_reg; // Counter enable
    logic [SEL_W-1:0] evt_sel_reg; // Counted event select
    logic [CNT_W-1:0] err_cnt_reg; // Link error count
    logic [CNT_W-1:0] err_cnt_next;
    logic [FLAG_N-1:0] flag_reg; // Sticky credit flags
    logic [FLAG_N-1:0] flag_next;
    logic [DAT_W-1:0] rd_data;
    logic [1:0] clkreq_sync_reg; // Line synchroniser
    logic pin_low_reg; // Open-drain drive value
    logic ptm_active_next;
    logic ptm_root_next;
    logic drive_w;

    // Bus decode
    wire req = wb_cyc_i && wb_stb_i;
    wire [DAT_W-1:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                              {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire wr_go = req && wb_we_i && wb_ack_o;
    wire [ADR_W-3:0] word = wb_adr_i[ADR_W-1:2];
    wire hit_ptm = word == ADR_TIME_MEASURE[ADR_W-1:2];
    wire hit_wait = word == ADR_CLKREQ_WAIT[ADR_W-1:2];
    wire hit_delay = word == ADR_L1SS_DELAY[ADR_W-1:2];
    wire hit_sp2 = word == ADR_SPARE_TWO[ADR_W-1:2];
    wire hit_sp3 = word == ADR_SPARE_THREE[ADR_W-1:2];
    wire hit_sp4 = word == ADR_SPARE_FOUR[ADR_W-1:2];
    wire hit_err = word == ADR_ERR_COUNTER[ADR_W-1:2];

    // Merged write values, old bits kept on disabled lanes
    wire [DAT_W-1:0] wdat = wb_dat_i & wmask;
    wire [DAT_W-1:0] ptm_old = {16'h0000, gran_reg, 6'h00, ptm_root_reg, ptm_en_reg};
    wire [DAT_W-1:0] ptm_new = (ptm_old & ~wmask) | wdat;
    wire [DAT_W-1:0] wait_new = ({12'h000, wait_reg} & ~wmask) | wdat;
    wire [DAT_W-1:0] delay_new = ({hw_delay_reg, sw_delay_reg} & ~wmask) | wdat;
    wire [DAT_W-1:0] sp2_new = (spare_two_reg & ~wmask) | wdat;
    wire [DAT_W-1:0] sp3_new = (spare_three_reg & ~wmask) | wdat;
    wire [DAT_W-1:0] sp4_new = (spare_four_reg & ~wmask) | wdat;
    wire [DAT_W-1:0] err_ctl_new = ({cnt_en_reg, 2'b00, evt_sel_reg, 24'h00_0000} & ~wmask)
                                   | wdat;

    // Counter clear fires on a written one, flags clear on written ones
    wire clr_pulse = wr_go && hit_err && wdat[CNT_CLR_BIT];
    wire [FLAG_N-1:0] flag_clr = (wr_go && hit_err) ?
                                 wdat[FLAG_LSB +: FLAG_N] : '0;
    wire [FLAG_N-1:0] flag_set = {posted_credit_err_i, nonposted_credit_fault_i,
                                  cpl_credit_err_i};

    // Event source table indexed by the selector, reserved codes stay zero
    logic [31:0] evt_vec;
    always_comb begin
        evt_vec = '0;
        evt_vec[EVT_TRAINING] = training_err_i;
        evt_vec[EVT_UNCORR] = uncorrectable_status_event_i;
        evt_vec[EVT_ACCESS] = acs_err_i;
        evt_vec[EVT_REPLAY] = replay_rollover_i || replay_timeout_i;
        evt_vec[EVT_CPL_CREDIT] = cpl_credit_err_i;
        evt_vec[EVT_NP_CREDIT] = nonposted_credit_fault_i;
        evt_vec[EVT_POST_CREDIT] = posted_credit_err_i;
        evt_vec[EVT_NACK_A] = rx_nack_i;
        evt_vec[EVT_NACK_B] = rx_nack_i;
        evt_vec[EVT_TX_RECOV] = tx_recovery_i;
        evt_vec[EVT_RX_RECOV] = rx_recovery_i;
    end
    wire evt_hit = evt_vec[evt_sel_reg];

    // Clear first, then a saturating step while enabled
    assign err_cnt_next = clr_pulse ? '0 :
        (cnt_en_reg && evt_hit && err_cnt_reg != CNT_MAX) ?
        err_cnt_reg + 16'h0001 : err_cnt_reg;

    // A new error beats a clear in the same cycle
    assign flag_next = (flag_reg & ~flag_clr) | flag_set;

    // Time measurement role outputs
    assign ptm_active_next = ptm_en_reg;
    assign ptm_root_next = ptm_en_reg && ptm_root_reg;

    // Read mux; clear bit always reads one
    assign rd_data = hit_ptm ? ptm_old :
        hit_wait ? {12'h000, wait_reg} :
        hit_delay ? {hw_delay_reg, sw_delay_reg} :
        hit_sp2 ? spare_two_reg :
        hit_sp3 ? spare_three_reg :
        hit_sp4 ? spare_four_reg :
        hit_err ? {cnt_en_reg, 1'b1, 1'b0, evt_sel_reg, 5'h00, flag_reg, err_cnt_reg} :
        32'h0000_0000;

    // Bus answer: one wait state, ack drops after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
            wb_dat_o <= rd_data;
        end
    end

    // Time measurement control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptm_en_reg <= 1'b0;
            ptm_root_reg <= 1'b0;
            gran_reg <= '0;
        end else if (wr_go && hit_ptm) begin
            ptm_en_reg <= ptm_new[PTM_EN_BIT];
            ptm_root_reg <= ptm_new[PTM_ROOT_BIT];
            gran_reg <= ptm_new[GRAN_LSB +: GRAN_W];
        end
    end

    // Low-power timing registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_reg <= WAIT_RST;
            sw_delay_reg <= DELAY_RST;
            hw_delay_reg <= DELAY_RST;
        end else begin
            if (wr_go && hit_wait) begin
                wait_reg <= wait_new[WAIT_W-1:0];
            end
            if (wr_go && hit_delay) begin
                sw_delay_reg <= delay_new[DELAY_W-1:0];
                hw_delay_reg <= delay_new[HW_DELAY_LSB +: DELAY_W];
            end
        end
    end

    // Spare control words
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spare_two_reg <= SPARE_RST;
            spare_three_reg <= SPARE_RST;
            spare_four_reg <= SPARE_FOUR_RST;
        end else begin
            if (wr_go && hit_sp2) begin
                spare_two_reg <= sp2_new;
            end
            if (wr_go && hit_sp3) begin
                spare_three_reg <= sp3_new;
            end
            if (wr_go && hit_sp4) begin
                spare_four_reg <= sp4_new;
            end
        end
    end

    // Error counter control and status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_en_reg <= 1'b0;
            evt_sel_reg <= EVT_TRAINING;
            err_cnt_reg <= '0;
            flag_reg <= '0;
        end else begin
            if (wr_go && hit_err) begin
                cnt_en_reg <= err_ctl_new[CNT_EN_BIT];
                evt_sel_reg <= err_ctl_new[SEL_LSB +: SEL_W];
            end
            err_cnt_reg <= err_cnt_next;
            flag_reg <= flag_next;
        end
    end

    // Role outputs and the line synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptm_active_o <= 1'b0;
            ptm_root_o <= 1'b0;
            clkreq_sync_reg <= 2'b11;
            pin_low_reg <= 1'b0;
        end else begin
            ptm_active_o <= ptm_active_next;
            ptm_root_o <= ptm_root_next;
            clkreq_sync_reg <= {clkreq_sync_reg[0], clock_request_n_i};
            pin_low_reg <= 1'b0;
        end
    end
    assign clock_request_n_o = pin_low_reg;

    // L1 to L1.1 sequencing and clock request handling
    sppe_l1ss_ctrl u_l1ss (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_l1_i(in_l1_i),
        .hw_ctrl_i(hw_ctrl_i),
        .sw_delay_i(sw_delay_reg),
        .hw_delay_i(hw_delay_reg),
        .wait_i(wait_reg),
        .clkreq_n_i(clkreq_sync_reg[1]),
        .drive_o(drive_w),
        .substate_o(l1_substate_o),
        .fallback_o(l1_fallback_o)
    );
    assign clock_request_n_oe_n_o = !drive_w;

    // Checks
    chk_root_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        ptm_root_o |-> ptm_active_o)
        else $error("root role without enable");
    chk_ptm_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !ptm_en_reg |=> !ptm_active_o && !ptm_root_o)
        else $error("measurement role while disabled");
    chk_cnt_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!cnt_en_reg && !clr_pulse) |=> $stable(err_cnt_reg))
        else $error("counter moved while disabled");
    chk_cnt_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        clr_pulse |=> err_cnt_reg == 16'h0000)
        else $error("clear did not zero the counter");
    chk_cnt_step_one: assert property (@(posedge clk_i) disable iff (rst_i)
        (cnt_en_reg && evt_hit && !clr_pulse && err_cnt_reg != CNT_MAX)
        |=> err_cnt_reg == $past(err_cnt_reg) + 16'h0001)
        else $error("counter did not step by one");
    chk_cnt_saturate: assert property (@(posedge clk_i) disable iff (rst_i)
        (err_cnt_reg == CNT_MAX && !clr_pulse) |=> err_cnt_reg == CNT_MAX)
        else $error("counter wrapped");
    chk_flag_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        cpl_credit_err_i |=> flag_reg[0])
        else $error("credit error flag not set");
    chk_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        (flag_reg[1] && !flag_clr[1]) |=> flag_reg[1])
        else $error("credit flag lost without clear");
    chk_clear_reads_one: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && !wb_we_i && hit_err) |-> wb_dat_o[CNT_CLR_BIT])
        else $error("clear bit read as zero");
endmodule

// [tb/sppe_partner.sv]
`timescale 1ns/1ps
module sppe_partner (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Sync reset, active high
    input wire logic port_oe_n_i, // Low while the port pulls the line
    input wire logic port_dat_i, // Port drive value
    input wire logic [15:0] rel_dly_i, // Cycles before the partner lets go
    output logic line_o // Resolved line level
);
    logic [15:0] held_reg; // Cycles since the port let go
    logic pull; // Partner pulls the line low
    // Count how long the port has been released; restart whenever it drives
    always_ff @(posedge clk_i) begin
        if (rst_i || !port_oe_n_i) begin
            held_reg <= 16'h0000;
        end else if (held_reg != 16'hFFFF) begin
            held_reg <= held_reg + 16'h0001;
        end
    end
    // Partner keeps asking for clock until its own release time; FFFF lets go only once the count saturates at FFFF
    assign pull = (held_reg < rel_dly_i);
    // Open-drain wired-OR with pull-up: either party pulling low wins
    assign line_o = ((!port_oe_n_i && !port_dat_i) || pull) ? 1'b0 : 1'b1;
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import sppe_pkg::*;
    typedef struct packed {
        logic [11:0] adr; logic [31:0] rstv; logic [31:0] wdat; logic [31:0] expv;
    } sppe_row_s;
    // Reset value, write data and read-back value per register; 0x200 is unmapped
    sppe_row_s rows [8] = '{
        '{ADR_TIME_MEASURE, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_FF03},
        '{ADR_CLKREQ_WAIT, 32'h0000_0FFF, 32'hFFFF_FFFF, 32'h000F_FFFF},
        '{ADR_L1SS_DELAY, 32'h01FF_01FF, 32'h1234_5678, 32'h1234_5678},
        '{ADR_SPARE_TWO, 32'h0000_0000, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
        '{ADR_SPARE_THREE, 32'h0000_0000, 32'h0F0F_F0F0, 32'h0F0F_F0F0},
        '{ADR_SPARE_FOUR, 32'h000F_FFFF, 32'hFFFF_0000, 32'hFFFF_0000},
        '{ADR_ERR_COUNTER, 32'h4000_0000, 32'h1F00_0000, 32'h5F00_0000},
        '{12'h200, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000}};
    // Selector codes and the event input each one counts
    logic [4:0] codes [12] = '{EVT_TRAINING, EVT_UNCORR, EVT_ACCESS, EVT_REPLAY, EVT_REPLAY,
        EVT_CPL_CREDIT, EVT_NP_CREDIT, EVT_POST_CREDIT, EVT_NACK_A, EVT_NACK_B, EVT_TX_RECOV,
        EVT_RX_RECOV};
    int evi [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 8, 10, 9};
    logic clk_i, rst_i, cyc, we, ack, oe_n, n_o, line, sub, fb, act, root, in_l1, hw;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, dat_o, rd;
    logic [10:0] ev, m;
    logic [15:0] rel_dly;
    int n_fail = 0, cmp_count = 0, cyc_cnt = 0, lat;
    sppe_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .training_err_i(ev[0]), .uncorrectable_status_event_i(ev[1]), .acs_err_i(ev[2]),
        .replay_rollover_i(ev[3]), .replay_timeout_i(ev[4]), .cpl_credit_err_i(ev[5]),
        .nonposted_credit_fault_i(ev[6]), .posted_credit_err_i(ev[7]), .rx_nack_i(ev[8]),
        .rx_recovery_i(ev[9]), .tx_recovery_i(ev[10]), .in_l1_i(in_l1), .hw_ctrl_i(hw),
        .clock_request_n_i(line), .clock_request_n_o(n_o), .clock_request_n_oe_n_o(oe_n),
        .l1_substate_o(sub), .l1_fallback_o(fb), .ptm_active_o(act), .ptm_root_o(root));
    sppe_partner partner (.clk_i(clk_i), .rst_i(rst_i), .port_oe_n_i(oe_n), .port_dat_i(n_o),
        .rel_dly_i(rel_dly), .line_o(line));
    // Free-running core clock, 8 ns period
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Classic single cycle; held until ack is sampled high, then released
    task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        // Ack ends this wait; only the bench timeout ends a hang
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    // Compare a value and count the result
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Hold the given event inputs high for n cycles
    task automatic pulse(input logic [10:0] mk, input int n);
        @(posedge clk_i);
        ev <= mk;
        repeat (n) @(posedge clk_i);
        ev <= 11'h000;
    endtask
    // Count cycles until release (0) or the fallback pulse (1) shows
    task automatic wait_for(input int which);
        lat = 0;
        do begin
            @(posedge clk_i);
            lat++;
        end while ((which ? fb : oe_n) !== 1'b1 && lat < 500);
    endtask
    // Print the totals and the verdict, then stop
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 90000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        rst_i = 1'b1; cyc = 1'b0; we = 1'b0; adr = 12'h000; sel = 4'h0; wdat = 32'h0;
        ev = 11'h000; in_l1 = 1'b0; hw = 1'b0; rel_dly = 16'h0002;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, then write and read back every register
        foreach (rows[i]) begin
            bus(1'b0, rows[i].adr, 4'hF, 32'h0);
            check("reset value", rows[i].rstv, rd);
            bus(1'b1, rows[i].adr, 4'hF, rows[i].wdat);
            bus(1'b0, rows[i].adr, 4'hF, 32'h0);
            check("read back", rows[i].expv, rd);
        end
        bus(1'b1, ADR_SPARE_TWO, 4'h1, 32'hFFFF_FFFF);
        bus(1'b0, ADR_SPARE_TWO, 4'hF, 32'h0);
        check("byte lane", 32'hA5A5_5AFF, rd);
        $display("test registers done");
        // Enable and root select combinations
        for (int v = 0; v < 4; v++) begin
            bus(1'b1, ADR_TIME_MEASURE, 4'hF, 32'(v));
            repeat (2) @(posedge clk_i);
            check("ptm outs", {30'h0, v[0], v[0] & v[1]}, {30'h0, act, root});
        end
        // Every named selector code: other events ignored, selected one counted
        foreach (codes[i]) begin
            bus(1'b1, ADR_ERR_COUNTER, 4'hF, {3'b110, codes[i], 24'h0});
            m = (codes[i] == EVT_REPLAY) ? 11'h018 : (11'h001 << evi[i]);
            pulse(~m, 2);
            pulse(11'h001 << evi[i], 3);
            bus(1'b0, ADR_ERR_COUNTER, 4'hF, 32'h0);
            check("count", {3'b110, codes[i], 24'h3}, rd & 32'hFF00_FFFF);
        end
        // Counter disabled: events ignored, count kept
        bus(1'b1, ADR_ERR_COUNTER, 4'hF, 32'h0000_0000);
        pulse(11'h001, 2);
        bus(1'b0, ADR_ERR_COUNTER, 4'hF, 32'h0);
        check("count off", 32'h4000_0003, rd & 32'hFF00_FFFF);
        // Sticky credit flags and write-one clear
        bus(1'b1, ADR_ERR_COUNTER, 4'hF, 32'hC007_0000);
        bus(1'b0, ADR_ERR_COUNTER, 4'hF, 32'h0);
        check("flags cleared", 32'hC000_0000, rd);
        pulse(11'h040, 1);
        bus(1'b1, ADR_ERR_COUNTER, 4'hF, 32'hC001_0000);
        bus(1'b0, ADR_ERR_COUNTER, 4'hF, 32'h0);
        check("np flag", 32'hC002_0000, rd);
        bus(1'b1, ADR_ERR_COUNTER, 4'hF, 32'h8002_0000);
        bus(1'b0, ADR_ERR_COUNTER, 4'hF, 32'h0);
        check("np flag off", 32'hC000_0000, rd);
        // Saturation at the top, then clear
        pulse(11'h001, 65540);
        bus(1'b0, ADR_ERR_COUNTER, 4'hF, 32'h0);
        check("saturate", 32'hC000_FFFF, rd);
        bus(1'b1, ADR_ERR_COUNTER, 4'hF, 32'hC000_0000);
        bus(1'b0, ADR_ERR_COUNTER, 4'hF, 32'h0);
        check("clear", 32'hC000_0000, rd);
        $display("test counter done");
        // Prompt partner: software then hardware entry delay
        bus(1'b1, ADR_CLKREQ_WAIT, 4'hF, 32'h0000_0010);
        bus(1'b1, ADR_L1SS_DELAY, 4'hF, 32'h0040_0010);
        for (int h = 0; h < 2; h++) begin
            hw <= h[0];
            in_l1 <= 1'b1;
            wait_for(0);
            check("entry delay", 1, 32'(lat >= (h ? 32 : 8) && lat <= (h ? 36 : 12)));
            repeat (40) @(posedge clk_i);
            check("settled", 32'h3, {30'h0, oe_n, sub});
            in_l1 <= 1'b0;
            repeat (4) @(posedge clk_i);
            check("back in L0", 32'h0, {30'h0, oe_n, sub});
        end
        // Slow partner: port redrives and falls back after the wait interval
        rel_dly <= 16'hFFFF;
        hw <= 1'b0;
        in_l1 <= 1'b1;
        wait_for(0);
        wait_for(1);
        check("wait interval", 1, 32'(lat >= 20 && lat <= 26));
        @(posedge clk_i);
        check("fallback", 32'h0, {29'h0, n_o, oe_n, sub});
        in_l1 <= 1'b0;
        $display("test link done");
        // Mid-run reset puts line drive and registers back to reset state
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check("reset outs", 32'h0, {29'h0, n_o, oe_n, sub});
        bus(1'b0, ADR_L1SS_DELAY, 4'hF, 32'h0);
        check("reset delay", 32'h01FF_01FF, rd);
        $display("test reset done");
        report_and_stop();
    end
endmodule
